// [rtl/ppg_map.svh]
// register offsets, field positions and reset values of the four-pin port
// assumes a 32-bit word-aligned AHB-Lite register window
`ifndef PPG_MAP_SVH
`define PPG_MAP_SVH
`define PPG_OFS_DATA      8'h00
`define PPG_OFS_DIRECTION 8'h04
`define PPG_OFS_FUNCSEL   8'h08
`define PPG_DATA_RESET    4'hf
`define PPG_DIR_RESET     4'h0
`define PPG_FSEL_RESET    4'h0
`define PPG_RSVD_HIGH     4'hf
`define PPG_FSEL_PULSE_OUTPUT_ONE_SELECT_BIT 0
`define PPG_FSEL_PULSE_OUTPUT_TWO_SELECT_BIT 1
`define PPG_FSEL_IRQ_BIT  2
`define PPG_FSEL_RSVD_BIT 3
`endif

// [rtl/ppg_pkg.sv]
// types shared by the four-pin port
// assumes nothing of its surroundings
package ppg_pkg;
  typedef struct packed {
    logic [3:0] out_val;
    logic [3:0] out_en_n;
  } ppg_pin_drive_t;
  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  trans;
    logic [2:0]  size;
  } ppg_ahb_addr_t;
endpackage

// [rtl/ppg_port.sv]
// four-pin gpio port with pwm and interrupt alternate functions, ahb-lite slave
// assumes pins synchronous to i_clk, single word transfers only
//
// What this block does
// - four data latch bits, reset to one
// - output pins read back latched value
// - input pins read back live level
// - bits seven to four read one
// - direction one drives, zero inputs; reset zero
// - direction register reads ones in bits seven to zero, zero above
// - gpio settings ignored under alternate function
// - function bit two makes pin two interrupt
// - pin two interrupt plus output prohibited
// - function bits one, zero select pwm
// - pwm select drives pin, ignores direction
// - pin three follows direction only
`timescale 1ns/1ps
`default_nettype none
`include "ppg_map.svh"
module ppg_port #(
  parameter int PIN_COUNT = 4
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic      [31:0]           o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  input  wire logic [3:0]            i_pin,
  output ppg_pkg::ppg_pin_drive_t    o_pin_drive,
  input  wire logic                  i_pulse_output_one_select,
  input  wire logic                  i_pulse_output_two_select,
  output logic                       o_irq
);
  import ppg_pkg::*;

  // register map holds exactly four pins
  if (PIN_COUNT != 4) begin : g_pin_count_check
    $error("unsupported pin count");
  end

  logic [3:0]    data_latch;
  logic [3:0]    direction;
  logic [3:0]    func_sel;
  ppg_ahb_addr_t ap;
  logic [31:0]   rdata;

  // address phase capture; always zero wait state
  wire take = i_hsel & i_hready & i_htrans[1];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ap <= '0;
    end else if (i_hready) begin
      ap <= '{sel: take, addr: i_haddr, write: i_hwrite, trans: i_htrans, size: i_hsize};
    end
  end

  wire wr_phase = ap.sel & ap.write;
  wire rd_take  = take & ~i_hwrite;
  wire wr_data  = wr_phase & (ap.addr[7:0] == `PPG_OFS_DATA);
  wire wr_dir   = wr_phase & (ap.addr[7:0] == `PPG_OFS_DIRECTION);
  wire wr_fsel  = wr_phase & (ap.addr[7:0] == `PPG_OFS_FUNCSEL);

  // only low nibble is stored, upper bits ignore writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_latch <= `PPG_DATA_RESET;
    end else if (wr_data) begin
      data_latch <= i_hwdata[3:0];
    end
  end

  // write-only: never returned on a read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      direction <= `PPG_DIR_RESET;
    end else if (wr_dir) begin
      direction <= i_hwdata[3:0];
    end
  end

  // bit three stored as written; software must keep it zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      func_sel <= `PPG_FSEL_RESET;
    end else if (wr_fsel) begin
      func_sel <= i_hwdata[3:0];
    end
  end

  wire sel_pulse_output_one_select = func_sel[`PPG_FSEL_PULSE_OUTPUT_ONE_SELECT_BIT];
  wire sel_pulse_output_two_select = func_sel[`PPG_FSEL_PULSE_OUTPUT_TWO_SELECT_BIT];
  wire sel_irq  = func_sel[`PPG_FSEL_IRQ_BIT];

  // pin drive; enable is active low. irq with direction 1 is prohibited,
  // pin two is then held as input so the interrupt still sees the pin
  wire [3:0] drive_en;
  assign drive_en[0] = sel_pulse_output_one_select | direction[0];
  assign drive_en[1] = sel_pulse_output_two_select | direction[1];
  assign drive_en[2] = ~sel_irq & direction[2];
  assign drive_en[3] = direction[3];
  wire [3:0] drive_val = {data_latch[3], data_latch[2],
                          sel_pulse_output_two_select ? i_pulse_output_two_select : data_latch[1],
                          sel_pulse_output_one_select ? i_pulse_output_one_select : data_latch[0]};

  // data outputs from flip-flops: one cycle after register change
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_drive <= '{out_val: `PPG_DATA_RESET, out_en_n: 4'hf};
      o_irq       <= 1'h0;
    end else begin
      o_pin_drive <= '{out_val: drive_val, out_en_n: ~drive_en};
      o_irq       <= sel_irq & i_pin[2];
    end
  end

  // readback select per pin by direction bit
  wire [3:0] data_view = (direction & data_latch) | (~direction & i_pin);
  wire [7:0] ofs = i_haddr[7:0];
  wire [31:0] next_rdata =
      (ofs == `PPG_OFS_DATA)      ? {24'h000000, `PPG_RSVD_HIGH, data_view} :
      (ofs == `PPG_OFS_DIRECTION) ? {24'h000000, 8'hff} :
      (ofs == `PPG_OFS_FUNCSEL)   ? {24'h000000, `PPG_RSVD_HIGH, func_sel} :
                                    32'h00000000;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 32'h00000000;
    end else if (rd_take) begin
      rdata <= next_rdata;
    end
  end

  assign o_hrdata    = rdata;
  assign o_hreadyout = 1'h1;
  assign o_hresp     = 1'h0;

  a_data_reset: assert property (@(posedge i_clk) $fell(i_rst) |-> data_latch == 4'hf)
    else $error("data latch not all ones after reset");
  a_dir_read: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_take && i_haddr[7:0] == 8'h04 |=> o_hrdata == 32'h000000ff)
    else $error("direction read not all ones");
  a_data_rsvd: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_take && i_haddr[7:0] == 8'h00 |=> o_hrdata[7:4] == 4'hf && o_hrdata[31:8] == 24'h0)
    else $error("data reserved bits wrong");
  a_read_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_take && i_haddr[7:0] == 8'h00 |=> o_hrdata[3:0] == (($past(direction) & $past(data_latch))
      | (~$past(direction) & $past(i_pin))))
    else $error("data readback mismatch");
  a_read_pin_in: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_take && i_haddr[7:0] == 8'h00 && direction[3] == 1'h0 |=> o_hrdata[3] == $past(i_pin[3]))
    else $error("input pin not read live");
  a_pwm_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    sel_pulse_output_one_select |=> o_pin_drive.out_val[0] == $past(i_pulse_output_one_select) && !o_pin_drive.out_en_n[0])
    else $error("pwm one not on pin zero");
  a_irq_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !sel_irq |=> !o_irq)
    else $error("interrupt line active while unselected");
  a_irq_pin_in: assert property (@(posedge i_clk) disable iff (i_rst)
    sel_irq |=> o_pin_drive.out_en_n[2] && o_irq == $past(i_pin[2]))
    else $error("pin two not interrupt input");
  a_pin3_dir: assert property (@(posedge i_clk) disable iff (i_rst)
    1'h1 |=> o_pin_drive.out_en_n[3] == !$past(direction[3]))
    else $error("pin three enable not from direction");
  a_write_dir: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_dir |=> direction == $past(i_hwdata[3:0]) ##1 o_pin_drive.out_en_n[3] == !$past(direction[3]))
    else $error("direction write not applied");

  c_pulse_output_two_select_on: cover property (@(posedge i_clk) disable iff (i_rst) sel_pulse_output_two_select && i_pulse_output_two_select);
  c_irq_edge: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
  c_data_read: cover property (@(posedge i_clk) disable iff (i_rst) rd_take && i_haddr[7:0] == 8'h00);
  c_out_drive: cover property (@(posedge i_clk) disable iff (i_rst) o_pin_drive.out_en_n == 4'h0);
  c_irq_live: cover property (@(posedge i_clk) disable iff (i_rst) sel_irq && o_irq);

  a_dir_reset: assert property (@(posedge i_clk)
    $fell(i_rst) |->
    direction == `PPG_DIR_RESET)
    else $error("direction not cleared by reset");

  a_fsel_reset: assert property (@(posedge i_clk)
    $fell(i_rst) |->
    func_sel == `PPG_FSEL_RESET)
    else $error("function select not cleared by reset");

  a_drive_reset: assert property (@(posedge i_clk)
    $fell(i_rst) |->
    o_pin_drive.out_en_n == 4'hf)
    else $error("pins driven right after reset");

  a_irq_reset: assert property (@(posedge i_clk)
    $fell(i_rst) |->
    !o_irq)
    else $error("interrupt line active after reset");

  a_write_data: assert property (@(posedge i_clk)
    disable iff (i_rst) wr_data |=>
    data_latch == $past(i_hwdata[3:0]))
    else $error("data latch write not applied");

  a_write_fsel: assert property (@(posedge i_clk)
    disable iff (i_rst) wr_fsel |=>
    func_sel == $past(i_hwdata[3:0]))
    else $error("function select write not applied");

  a_data_hold: assert property (@(posedge i_clk)
    disable iff (i_rst) !wr_data |=>
    $stable(data_latch))
    else $error("data latch changed without write");

  a_dir_hold: assert property (@(posedge i_clk)
    disable iff (i_rst) !wr_dir |=>
    $stable(direction))
    else $error("direction changed without write");

  a_fsel_hold: assert property (@(posedge i_clk)
    disable iff (i_rst) !wr_fsel |=>
    $stable(func_sel))
    else $error("function select changed without write");

  a_fsel_read: assert property (@(posedge i_clk)
    disable iff (i_rst) rd_take && i_haddr[7:0] == `PPG_OFS_FUNCSEL |=>
    o_hrdata == {24'h000000, 4'hf, $past(func_sel)})
    else $error("function select readback wrong");

  a_read_unmapped: assert property (@(posedge i_clk)
    disable iff (i_rst) rd_take && i_haddr[7:0] > `PPG_OFS_FUNCSEL |=>
    o_hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_read_latch_out: assert property (@(posedge i_clk)
    disable iff (i_rst) rd_take && i_haddr[7:0] == `PPG_OFS_DATA && direction[0] |=>
    o_hrdata[0] == $past(data_latch[0]))
    else $error("output pin not read from latch");

  a_read_pin_live: assert property (@(posedge i_clk)
    disable iff (i_rst) rd_take && i_haddr[7:0] == `PPG_OFS_DATA && !direction[0] |=>
    o_hrdata[0] == $past(i_pin[0]))
    else $error("input pin zero not read live");

  a_read_hold: assert property (@(posedge i_clk)
    disable iff (i_rst) !rd_take |=>
    $stable(o_hrdata))
    else $error("read data changed without read");

  a_pulse_output_two_select_drive: assert property (@(posedge i_clk)
    disable iff (i_rst) sel_pulse_output_two_select |=>
    o_pin_drive.out_val[1] == $past(i_pulse_output_two_select) && !o_pin_drive.out_en_n[1])
    else $error("pwm two not on pin one");

  a_gpio_pin0: assert property (@(posedge i_clk)
    disable iff (i_rst) !sel_pulse_output_one_select |=>
    o_pin_drive.out_en_n[0] == !$past(direction[0]) && o_pin_drive.out_val[0] == $past(data_latch[0]))
    else $error("pin zero gpio settings not applied");

  a_gpio_pin1: assert property (@(posedge i_clk)
    disable iff (i_rst) !sel_pulse_output_two_select |=>
    o_pin_drive.out_en_n[1] == !$past(direction[1]) && o_pin_drive.out_val[1] == $past(data_latch[1]))
    else $error("pin one gpio settings not applied");

  a_gpio_pin2: assert property (@(posedge i_clk)
    disable iff (i_rst) !sel_irq |=>
    o_pin_drive.out_en_n[2] == !$past(direction[2]) && o_pin_drive.out_val[2] == $past(data_latch[2]))
    else $error("pin two gpio settings not applied");

  a_irq_no_drive: assert property (@(posedge i_clk)
    disable iff (i_rst) sel_irq && direction[2] |=>
    o_pin_drive.out_en_n[2])
    else $error("pin two driven in prohibited setting");

  a_pin2_output: assert property (@(posedge i_clk)
    disable iff (i_rst) !sel_irq && direction[2] |=>
    !o_pin_drive.out_en_n[2])
    else $error("pin two not driven as output");

  a_pin3_value: assert property (@(posedge i_clk)
    disable iff (i_rst) 1'h1 |=>
    o_pin_drive.out_val[3] == $past(data_latch[3]))
    else $error("pin three value not from latch");

  a_bus_okay: assert property (@(posedge i_clk)
    disable iff (i_rst) 1'h1 |->
    o_hreadyout && !o_hresp)
    else $error("bus response not ready and okay");

  a_pulse_output_one_select_no_dir: assert property (@(posedge i_clk)
    disable iff (i_rst) sel_pulse_output_one_select && !direction[0] |=>
    !o_pin_drive.out_en_n[0])
    else $error("pwm one pin follows direction");

  a_input_undriven: assert property (@(posedge i_clk)
    disable iff (i_rst) !sel_pulse_output_one_select && !direction[0] |=>
    o_pin_drive.out_en_n[0])
    else $error("input pin zero driven");

  a_irq_follows: assert property (@(posedge i_clk)
    disable iff (i_rst) sel_irq && i_pin[2] |=>
    o_irq)
    else $error("interrupt line not following pin two");
endmodule
`default_nettype wire

// [verif/ppg_pins.sv]
// board-side pin model: resolves each pin from the port drive and a board level
// assumes the pin drive struct of ppg_pkg
`timescale 1ns/1ps
`default_nettype none
module ppg_pins (
  input  wire ppg_pkg::ppg_pin_drive_t i_drive,
  input  wire logic [3:0]              i_ext,
  output logic      [3:0]              o_pin
);
  import ppg_pkg::*;
  // a driven pin wins over the board level
  assign o_pin = (i_drive.out_val & ~i_drive.out_en_n) | (i_ext & i_drive.out_en_n);
endmodule
`default_nettype wire

// [verif/ppg_port_test.sv]
// self-checking bench for the four-pin port over ahb-lite
// assumes the board pin model ppg_pins and the map header
`timescale 1ns/1ps
`default_nettype none
`include "ppg_map.svh"
module ppg_port_test;
  import ppg_pkg::*;
  logic           i_clk = 1'h0, i_rst = 1'h1, hwrite = 1'h0, pulse_output_one_select = 1'h1, pulse_output_two_select = 1'h0;
  logic [1:0]     htrans = 2'h0;
  logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic           hready, hresp, irq;
  logic [3:0]     ext = 4'ha, pin;
  ppg_pin_drive_t drv;
  int             fail_count = 0, n_checks = 0;
  ppg_port u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(1'h1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_pin(pin), .o_pin_drive(drv), .i_pulse_output_one_select(pulse_output_one_select),
    .i_pulse_output_two_select(pulse_output_two_select), .o_irq(irq));
  ppg_pins u_pins (.i_drive(drv), .i_ext(ext), .o_pin(pin));
  initial forever #2 i_clk = ~i_clk;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge i_clk);
    while (hready !== 1'h1) @(posedge i_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'h1) @(posedge i_clk);
    rd = hrdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // registered pin drive lags the write by one edge
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    check({24'h0, drv}, 32'hff);
    check({31'h0, hresp}, 32'h0);
    bus(1'h0, `PPG_OFS_DATA, 32'h0);
    check(rd, 32'hfa);
    bus(1'h0, `PPG_OFS_DIRECTION, 32'h0);
    check(rd, 32'hff);
    bus(1'h0, `PPG_OFS_FUNCSEL, 32'h0);
    check(rd, 32'hf0);
    bus(1'h0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_out;
    bus(1'h1, `PPG_OFS_DIRECTION, 32'hffffffff);
    bus(1'h0, `PPG_OFS_DATA, 32'h0);
    check(rd, 32'hff);
    bus(1'h1, `PPG_OFS_DATA, 32'hffffff05);
    bus(1'h0, `PPG_OFS_DATA, 32'h0);
    check(rd, 32'hf5);
    settle;
    check({24'h0, drv}, 32'h50);
    $display("test output done");
  endtask
  task automatic t_alt;
    @(posedge i_clk);
    ext <= 4'h4;
    bus(1'h1, `PPG_OFS_DIRECTION, 32'hb);
    bus(1'h1, `PPG_OFS_FUNCSEL, 32'h7);
    settle;
    // pin two is undriven, so its out_val is masked
    check({24'h0, drv.out_val & 4'hb, drv.out_en_n}, 32'h14);
    check({31'h0, irq}, 32'h1);
    @(posedge i_clk);
    pulse_output_one_select <= 1'h0;
    pulse_output_two_select <= 1'h1;
    settle;
    check({24'h0, drv.out_val & 4'hb, drv.out_en_n}, 32'h24);
    bus(1'h0, `PPG_OFS_FUNCSEL, 32'h0);
    check(rd, 32'hf7);
    bus(1'h1, `PPG_OFS_FUNCSEL, 32'h0);
    settle;
    check({31'h0, irq}, 32'h0);
    check({24'h0, drv.out_val & 4'hb, drv.out_en_n}, 32'h14);
    $display("test alternate done");
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    t_reset;
    t_out;
    t_alt;
    print_verdict;
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
